// ---- artpwm_consts.vh ----
// constants for the 8-bit auto-reload pwm and capture timer
// assumes: included by its bare name from the timer module and the bench
`ifndef ARTPWM_CONSTS_VH
`define ARTPWM_CONSTS_VH

// register indices; byte address is four times the index
`define ARTPWM_IDX_DUTY3 8'h73
`define ARTPWM_IDX_DUTY2 8'h74
`define ARTPWM_IDX_DUTY1 8'h75
`define ARTPWM_IDX_DUTY0 8'h76
`define ARTPWM_IDX_OUTCTL 8'h77
`define ARTPWM_IDX_TCS 8'h78
`define ARTPWM_IDX_CNT 8'h79
`define ARTPWM_IDX_RELOAD 8'h7A
`define ARTPWM_IDX_CCS 8'h7B
`define ARTPWM_IDX_CAP1 8'h7C
`define ARTPWM_IDX_CAP2 8'h7D

// timer_control_status fields
`define ARTPWM_TCS_EXTERNAL_CLOCK_SELECT 7
`define ARTPWM_TCS_CC_HI 6
`define ARTPWM_TCS_CC_LO 4
`define ARTPWM_TCS_RUN 3
`define ARTPWM_TCS_FORCE 2
`define ARTPWM_TCS_OIE 1
`define ARTPWM_TCS_OVF 0

// capture_control_status fields
`define ARTPWM_CCS_CS_HI 5
`define ARTPWM_CCS_CS_LO 4
`define ARTPWM_CCS_CIE_HI 3
`define ARTPWM_CCS_CIE_LO 2
`define ARTPWM_CCS_CF_HI 1
`define ARTPWM_CCS_CF_LO 0

// counter and reset values
`define ARTPWM_CNT_TOP 8'hFF
`define ARTPWM_RST_BYTE 8'h00
`define ARTPWM_PRESC_FULL 7'h7F

// axi responses
`define ARTPWM_RESP_OKAY 2'h0
`define ARTPWM_RESP_SLVERR 2'h2

`endif

// ---- artpwm_timer.v ----
// 8-bit auto-reload timer: prescaler, four pwm outputs, two input captures,
// registers on an axi4-lite slave with 8-bit registers in the low byte lane.
// assumes: pins are asynchronous to clk; the external clock is much slower than clk.
//
// The AXI4-Lite slave port is this design's own decision.
`include "artpwm_consts.vh"

// Operation
// RULE_01 - force reload bit reads zero; writing one reloads counter, clears prescaler
// RULE_02 - overflow interrupt enable gates the overflow request
// RULE_03 - overflow flag set on FFh to reload; cleared by reading control register
// RULE_04 - counter register reads live count and writes it even while running
// RULE_05 - every overflow loads the reload value into the counter
// RULE_06 - at overflow reload each pwm output takes its polarity-selected level
// RULE_07 - reload value sets shared period and duty resolution
// RULE_08 - four enable bits connect each pwm channel to its pin
// RULE_09 - output high at or below compare, low above; polarity inverts
// RULE_10 - polarity change inverts the output at once
// RULE_11 - each duty register is its channel compare value
// RULE_12 - capture edge select zero means falling, one means rising
// RULE_13 - capture interrupt enables gate each capture request
// RULE_14 - capture flag set on capture; cleared only by reading its capture register
// RULE_15 - top two capture control bits read as zero
// RULE_16 - capture registers hold the count at the active edge, hardware only
// RULE_17 - all registers reset to zero
// RULE_18 - clock select feeds prescaler from clk or external clock
// RULE_19 - three-bit field divides by one to 128 in powers of two
// RULE_20 - enable bit zero freezes prescaler and counter
// RULE_21 - at compare match the pin returns to its pre-overflow level
// RULE_22 - counter increments per prescaler tick from reload up to FFh
module artpwm_timer #(
    parameter ADDR_W = 12
) (
    input wire clk,
    input wire sys_rst,
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire ext_clk_pin,
    input wire [1:0] capture_input_pin,
    output reg [3:0] pulse_out_pin,
    output reg [3:0] pulse_out_oe,
    output reg overflow_irq,
    output reg [1:0] capture_irq
);

    // ==========================================================
    // helpers
    // ==========================================================
    // index of a mapped register, or 0 for an unmapped address
    function [7:0] reg_index;
        input [ADDR_W-1:0] addr;
        reg [7:0] idx;
        begin
            idx = addr[9:2];
            reg_index = (addr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}} && addr[1:0] == 2'b00 &&
                         idx >= `ARTPWM_IDX_DUTY3 && idx <= `ARTPWM_IDX_CAP2) ? idx : 8'h00;
        end
    endfunction

    // low prescaler bits that must be all ones for a tick at ratio 2^sel
    function [6:0] presc_mask;
        input [2:0] sel;
        begin
            presc_mask = `ARTPWM_PRESC_FULL >> (3'd7 - sel);
        end
    endfunction

    // ==========================================================
    // registers
    // ==========================================================
    reg [7:0] duty0, duty1, duty2, duty3;
    reg [3:0] out_enable;
    reg [3:0] channel_polarity;
    reg external_clock_select;
    reg [2:0] prescale_select;
    reg count_run;
    reg overflow_irq_enable;
    reg overflow_flag;
    reg [7:0] counter;
    reg [7:0] reload_bits;
    reg [1:0] capture_edge_rise;
    reg [1:0] capture_irq_enable;
    reg [1:0] capture_flag;
    reg [7:0] capture_value_ch1, capture_value_ch2;
    reg [6:0] presc;

    reg aw_hold, w_hold;
    reg [ADDR_W-1:0] awaddr_q;
    reg [7:0] wdata_q;
    reg wstrb0_q;

    // ==========================================================
    // pin synchronisers
    // ==========================================================
    // three stages; a change is believed only once stages two and three agree
    reg [2:0] sync1, sync2, sync3, level;

    always @(posedge clk) begin
        if (sys_rst) begin
            sync1 <= 3'h0;
            sync2 <= 3'h0;
            sync3 <= 3'h0;
            level <= 3'h0;
        end else begin
            sync1 <= {capture_input_pin, ext_clk_pin};
            sync2 <= sync1;
            sync3 <= sync2;
            level <= (sync2 & sync3) | (level & (sync2 ^ sync3));
        end
    end

    wire [2:0] next_level = (sync2 & sync3) | (level & (sync2 ^ sync3));
    wire [2:0] pin_rise = next_level & ~level;
    wire [2:0] pin_fall = ~next_level & level;

    // ==========================================================
    // bus decode
    // ==========================================================
    wire [7:0] wr_idx = reg_index(awaddr_q);
    wire wr_go = aw_hold && w_hold && !s_axi_bvalid;
    wire wr_en = wr_go && wstrb0_q;
    wire [7:0] rd_idx = reg_index(s_axi_araddr);
    wire rd_go = s_axi_arvalid && s_axi_arready;

    wire wr_tcs = wr_en && wr_idx == `ARTPWM_IDX_TCS;
    wire wr_cnt = wr_en && wr_idx == `ARTPWM_IDX_CNT;
    // RULE_01 force reload strobe
    wire force_reload = wr_tcs && wdata_q[`ARTPWM_TCS_FORCE];
    // RULE_03 read clears overflow
    wire rd_tcs = rd_go && rd_idx == `ARTPWM_IDX_TCS;
    // RULE_14 read of capture register clears flag
    wire [1:0] rd_cap = {rd_go && rd_idx == `ARTPWM_IDX_CAP2,
                         rd_go && rd_idx == `ARTPWM_IDX_CAP1};

    // ==========================================================
    // prescaler and counter
    // ==========================================================
    // RULE_18 clock source select
    wire src_tick = external_clock_select ? pin_rise[0] : 1'b1;
    // RULE_19 division by 2^select
    wire presc_done = (presc | ~presc_mask(prescale_select)) == `ARTPWM_PRESC_FULL;
    // RULE_20 frozen when not running
    wire cnt_tick = count_run && src_tick && presc_done;
    wire at_top = counter == `ARTPWM_CNT_TOP;
    // a software load in the same cycle wins over the overflow
    wire ovf_event = cnt_tick && at_top && !wr_cnt && !force_reload;

    // ==========================================================
    // capture events
    // ==========================================================
    // RULE_12 edge selection
    wire [1:0] cap_edge = (capture_edge_rise & pin_rise[2:1]) |
                          (~capture_edge_rise & pin_fall[2:1]);
    // transfer inhibited while the flag is up, unless the read clears it now
    wire [1:0] cap_take = cap_edge & (~capture_flag | rd_cap);

    // ==========================================================
    // read mux
    // ==========================================================
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        case (rd_idx)
            `ARTPWM_IDX_DUTY3: rd_byte = duty3;
            `ARTPWM_IDX_DUTY2: rd_byte = duty2;
            `ARTPWM_IDX_DUTY1: rd_byte = duty1;
            `ARTPWM_IDX_DUTY0: rd_byte = duty0;
            `ARTPWM_IDX_OUTCTL: rd_byte = {out_enable, channel_polarity};
            // RULE_01 force bit reads zero
            `ARTPWM_IDX_TCS: rd_byte = {external_clock_select, prescale_select, count_run,
                                        1'b0, overflow_irq_enable, overflow_flag};
            // RULE_04 live count
            `ARTPWM_IDX_CNT: rd_byte = counter;
            `ARTPWM_IDX_RELOAD: rd_byte = reload_bits;
            // RULE_15 reserved bits zero
            `ARTPWM_IDX_CCS: rd_byte = {2'b00, capture_edge_rise, capture_irq_enable,
                                        capture_flag};
            `ARTPWM_IDX_CAP1: rd_byte = capture_value_ch1;
            `ARTPWM_IDX_CAP2: rd_byte = capture_value_ch2;
            default: rd_byte = 8'h00;
        endcase
    end

    // ==========================================================
    // main sequential logic
    // ==========================================================
    integer i;
    wire [31:0] duty_all = {duty3, duty2, duty1, duty0};

    always @(posedge clk) begin
        if (sys_rst) begin
            // RULE_17 everything clears
            duty0 <= `ARTPWM_RST_BYTE;
            duty1 <= `ARTPWM_RST_BYTE;
            duty2 <= `ARTPWM_RST_BYTE;
            duty3 <= `ARTPWM_RST_BYTE;
            out_enable <= 4'h0;
            channel_polarity <= 4'h0;
            external_clock_select <= 1'b0;
            prescale_select <= 3'h0;
            count_run <= 1'b0;
            overflow_irq_enable <= 1'b0;
            overflow_flag <= 1'b0;
            counter <= `ARTPWM_RST_BYTE;
            reload_bits <= `ARTPWM_RST_BYTE;
            capture_edge_rise <= 2'h0;
            capture_irq_enable <= 2'h0;
            capture_flag <= 2'h0;
            capture_value_ch1 <= `ARTPWM_RST_BYTE;
            capture_value_ch2 <= `ARTPWM_RST_BYTE;
            presc <= 7'h00;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            awaddr_q <= {ADDR_W{1'b0}};
            wdata_q <= 8'h00;
            wstrb0_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ARTPWM_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `ARTPWM_RESP_OKAY;
            pulse_out_pin <= 4'h0;
            pulse_out_oe <= 4'h0;
            overflow_irq <= 1'b0;
            capture_irq <= 2'h0;
        end else begin
            // ---- write channels: address and data in either order
            if (!aw_hold && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (!w_hold && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold <= 1'b1;
                awaddr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold <= 1'b1;
                wdata_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wr_idx == 8'h00) ? `ARTPWM_RESP_SLVERR : `ARTPWM_RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end

            // ---- read channel: data one cycle after the address is taken
            if (!s_axi_rvalid && !rd_go) begin
                s_axi_arready <= 1'b1;
            end
            if (rd_go) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= (rd_idx == 8'h00) ? `ARTPWM_RESP_SLVERR : `ARTPWM_RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end

            if (wr_en) begin
                case (wr_idx)
                    // RULE_11 duty registers are the compare values
                    `ARTPWM_IDX_DUTY3: duty3 <= wdata_q;
                    `ARTPWM_IDX_DUTY2: duty2 <= wdata_q;
                    `ARTPWM_IDX_DUTY1: duty1 <= wdata_q;
                    `ARTPWM_IDX_DUTY0: duty0 <= wdata_q;
                    `ARTPWM_IDX_OUTCTL: begin
                        out_enable <= wdata_q[7:4];
                        channel_polarity <= wdata_q[3:0];
                    end
                    `ARTPWM_IDX_TCS: begin
                        external_clock_select <= wdata_q[`ARTPWM_TCS_EXTERNAL_CLOCK_SELECT];
                        prescale_select <= wdata_q[`ARTPWM_TCS_CC_HI:`ARTPWM_TCS_CC_LO];
                        count_run <= wdata_q[`ARTPWM_TCS_RUN];
                        overflow_irq_enable <= wdata_q[`ARTPWM_TCS_OIE];
                    end
                    `ARTPWM_IDX_RELOAD: reload_bits <= wdata_q;
                    `ARTPWM_IDX_CCS: begin
                        capture_edge_rise <= wdata_q[`ARTPWM_CCS_CS_HI:`ARTPWM_CCS_CS_LO];
                        capture_irq_enable <= wdata_q[`ARTPWM_CCS_CIE_HI:`ARTPWM_CCS_CIE_LO];
                    end
                    default: begin
                    end
                endcase
            end

            // ---- prescaler and counter
            if (force_reload) begin
                // RULE_01 reload and restart prescaler
                counter <= reload_bits;
                presc <= 7'h00;
            end else if (wr_cnt) begin
                // RULE_04 on-the-fly write
                counter <= wdata_q;
            end else if (cnt_tick) begin
                // RULE_05 reload at overflow; RULE_07 period is 256 minus reload
                if (at_top) begin
                    counter <= reload_bits;
                end else begin
                    // RULE_22 count up per tick
                    counter <= counter + 8'h01;
                end
            end
            if (!force_reload && count_run && src_tick) begin
                presc <= presc + 7'h01;
            end

            // ---- overflow flag, set wins over the read clear
            // RULE_03 set on overflow
            if (ovf_event) begin
                overflow_flag <= 1'b1;
            end else if (rd_tcs) begin
                overflow_flag <= 1'b0;
            end

            // ---- captures
            for (i = 0; i < 2; i = i + 1) begin
                // RULE_14 set on capture, set beats clear
                if (cap_take[i]) begin
                    capture_flag[i] <= 1'b1;
                end else if (rd_cap[i]) begin
                    capture_flag[i] <= 1'b0;
                end
            end
            // RULE_16 latch count at active edge
            if (cap_take[0]) begin
                capture_value_ch1 <= counter;
            end
            if (cap_take[1]) begin
                capture_value_ch2 <= counter;
            end

            // ---- pwm pins: level follows the count seen this cycle
            for (i = 0; i < 4; i = i + 1) begin
                // RULE_09 high at or below compare; RULE_10 polarity applied each cycle
                // RULE_06 reload lands below compare so the level flips at overflow
                // RULE_21 passing the compare restores the other level
                // RULE_08 enable connects the pin
                pulse_out_pin[i] <= out_enable[i] &
                                    ((counter <= duty_all[i*8 +: 8]) ^ channel_polarity[i]);
                pulse_out_oe[i] <= out_enable[i];
            end

            // ---- interrupt requests
            // RULE_02 overflow request gated
            overflow_irq <= overflow_irq_enable & overflow_flag;
            // RULE_13 capture requests gated
            capture_irq <= capture_irq_enable & capture_flag;
        end
    end

endmodule // artpwm_timer

// ---- artpwm_timer_asserts.sv ----
// concurrent checks on the register bus and pin outputs of the pwm timer
// assumes: bound to artpwm_timer, one clock, synchronous active-high reset
module artpwm_timer_asserts (
    input wire clk,
    input wire sys_rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [3:0] pulse_out_pin,
    input wire [3:0] pulse_out_oe,
    input wire overflow_irq,
    input wire [1:0] capture_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // ====================
    // register bus
    property p_wr_answer;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid;
    endproperty
    a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
    property p_b_refuse;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready && (s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2);
    endproperty
    a_b_refuse: assert property (p_b_refuse) else $error("write taken while busy");
    property p_b_single;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_b_single: assert property (p_b_single) else $error("extra write answer");
    property p_rd_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data changed");
    property p_r_refuse;
        s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_r_refuse: assert property (p_r_refuse) else $error("read lane or ready wrong");
    // ====================
    // pins
    property p_pin_off;
        (pulse_out_pin & ~pulse_out_oe) == 4'h0;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("disabled channel drives");
    property p_rst_quiet;
        disable iff (1'h0) sys_rst |=> pulse_out_oe == 4'h0 && !overflow_irq && capture_irq == 2'h0;
    endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs live in reset");
endmodule // artpwm_timer_asserts

bind artpwm_timer artpwm_timer_asserts u_chk (
    .clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pulse_out_pin(pulse_out_pin),
    .pulse_out_oe(pulse_out_oe), .overflow_irq(overflow_irq), .capture_irq(capture_irq)
);

// ---- artpwm_pin_model.sv ----
// board side of the timer: capture inputs and the external count clock
// assumes: driven by task calls from the bench, changes right after clk edges
module artpwm_pin_model (
    input wire clk,
    output reg ext_clk_pin = 1'h0,
    output reg [1:0] capture_input_pin = 2'h0
);
    timeunit 1ns;
    timeprecision 1ps;
    task set_cap(input integer ch, input lvl);
        begin
            @(posedge clk);
            capture_input_pin[ch] <= lvl;
        end
    endtask
    // clock stands low between bursts; 8 high, 8 low keeps it far below clk
    task ext_pulses(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clk);
                ext_clk_pin <= 1'h1;
                repeat (8) @(posedge clk);
                ext_clk_pin <= 1'h0;
                repeat (7) @(posedge clk);
            end
        end
    endtask
endmodule // artpwm_pin_model

// ---- artpwm_timer_tb.sv ----
// self-checking bench for the pwm timer: axi4-lite master, pin model, checks
// assumes: 200 MHz clk, reset held 8 cycles, fixed lfsr seed
`include "artpwm_consts.vh"
module artpwm_timer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    reg clk = 1'h0;
    reg sys_rst = 1'h1;
    reg [11:0] awaddr = 12'h000;
    reg [11:0] araddr = 12'h000;
    reg [31:0] wdata = 32'h0;
    reg awvalid = 1'h0;
    reg wvalid = 1'h0;
    reg bready = 1'h0;
    reg arvalid = 1'h0;
    reg rready = 1'h0;
    wire awready, wready, bvalid, arready, rvalid, ext_clk, ovf_irq;
    wire [1:0] bresp, rresp, cap_pin, cap_irq;
    wire [31:0] rdata;
    wire [3:0] pwm, oe;
    integer miscompares = 0;
    integer n_checks = 0;
    integer k;
    reg [15:0] seed = 16'h2593;
    reg [7:0] rv, c, d, v, ccs;
    reg [1:0] rsp;
    always #2.5 clk = ~clk;
    artpwm_timer dut (
        .clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_clk_pin(ext_clk), .capture_input_pin(cap_pin), .pulse_out_pin(pwm),
        .pulse_out_oe(oe), .overflow_irq(ovf_irq), .capture_irq(cap_irq)
    );
    artpwm_pin_model pins (.clk(clk), .ext_clk_pin(ext_clk), .capture_input_pin(cap_pin));
    // ====================
    // helpers
    function [15:0] lfsr(input [15:0] s);
        lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function pwm_level(input [7:0] cnt, input [7:0] duty, input pol);
        pwm_level = (cnt <= duty) ^ pol;
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [7:0] idx, input [7:0] dat, input [1:0] er);
        reg a, w;
        begin
            a = 1'h1;
            w = 1'h1;
            @(posedge clk);
            awaddr <= {2'h0, idx, 2'h0};
            wdata <= {24'h0, dat};
            awvalid <= 1'h1;
            wvalid <= 1'h1;
            bready <= 1'h1;
            while (a || w) begin
                @(posedge clk);
                if (a && awready) begin
                    awvalid <= 1'h0;
                    a = 1'h0;
                end
                if (w && wready) begin
                    wvalid <= 1'h0;
                    w = 1'h0;
                end
            end
            @(posedge clk);
            while (bvalid !== 1'h1) @(posedge clk);
            bready <= 1'h0;
            chk(bresp, er);
        end
    endtask
    task rd(input [7:0] idx, output [7:0] dat, output [1:0] r);
        begin
            @(posedge clk);
            araddr <= {2'h0, idx, 2'h0};
            arvalid <= 1'h1;
            rready <= 1'h1;
            @(posedge clk);
            while (arready !== 1'h1) @(posedge clk);
            arvalid <= 1'h0;
            @(posedge clk);
            while (rvalid !== 1'h1) @(posedge clk);
            rready <= 1'h0;
            dat = rdata[7:0];
            r = rresp;
        end
    endtask
    task rdx(input [7:0] idx, input [7:0] exp);
        begin
            rd(idx, rv, rsp);
            chk(rv, exp);
        end
    endtask
    task conclude;
        begin
            $display("checks %0d miscompares %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0) begin
                $display("*** PASS ***");
            end else begin
                $display("*** FAIL ***");
            end
            $finish;
        end
    endtask
    // ====================
    // tests
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        for (k = 8'h73; k <= 8'h7D; k = k + 1) rdx(k[7:0], 8'h00);
        rd(8'h00, rv, rsp);
        chk(rsp, 2'h2);
        wr(8'h7E, 8'h55, 2'h2);
        wr(`ARTPWM_IDX_CCS, 8'hFF, 2'h0);
        rdx(`ARTPWM_IDX_CCS, 8'h3C);
        $display("test map done");
        wr(`ARTPWM_IDX_RELOAD, 8'hF0, 2'h0);
        wr(`ARTPWM_IDX_CNT, 8'hFC, 2'h0);
        wr(`ARTPWM_IDX_TCS, 8'h0A, 2'h0);
        repeat (12) @(posedge clk);
        chk(ovf_irq, 1'h1);
        wr(`ARTPWM_IDX_TCS, 8'h02, 2'h0);
        rdx(`ARTPWM_IDX_TCS, 8'h03);
        rdx(`ARTPWM_IDX_TCS, 8'h02);
        rd(`ARTPWM_IDX_CNT, c, rsp);
        chk(c >= 8'hF0, 1'h1);
        rdx(`ARTPWM_IDX_CNT, c);
        chk(ovf_irq, 1'h0);
        wr(`ARTPWM_IDX_CNT, 8'h33, 2'h0);
        wr(`ARTPWM_IDX_TCS, 8'h06, 2'h0);
        rdx(`ARTPWM_IDX_CNT, 8'hF0);
        rdx(`ARTPWM_IDX_TCS, 8'h02);
        seed = lfsr(seed);
        d = 8'hF0 | {5'h0, seed[2:0]};
        wr(`ARTPWM_IDX_DUTY0, d, 2'h0);
        wr(`ARTPWM_IDX_OUTCTL, 8'h10, 2'h0);
        wr(`ARTPWM_IDX_TCS, 8'h08, 2'h0);
        repeat (8) @(posedge clk);
        c = 8'h00;
        v = 8'h00;
        rv = {4'h0, pwm};
        repeat (32) begin
            @(posedge clk);
            c = c + {7'h0, pwm[0]};
            v = v + {7'h0, pwm[0] & ~rv[0]};
            rv = {4'h0, pwm};
        end
        chk(v, 8'h02);
        chk(c, 8'h02 * (d - 8'hEF));
        chk(ovf_irq, 1'h0);
        wr(`ARTPWM_IDX_TCS, 8'h00, 2'h0);
        rdx(`ARTPWM_IDX_TCS, 8'h01);
        $display("test overflow done");
        for (k = 0; k < 8; k = k + 1) begin
            seed = lfsr(seed);
            c = seed[7:0];
            seed = lfsr(seed);
            d = (k == 0) ? c : seed[15:8];
            v = (8'h10 | {7'h0, k[2]}) << k[1:0];
            wr(`ARTPWM_IDX_CNT, c, 2'h0);
            wr(`ARTPWM_IDX_DUTY0 - {6'h0, k[1:0]}, d, 2'h0);
            wr(`ARTPWM_IDX_OUTCTL, v, 2'h0);
            repeat (4) @(posedge clk);
            chk(oe, 4'h1 << k[1:0]);
            chk(pwm, {3'h0, pwm_level(c, d, k[2])} << k[1:0]);
        end
        wr(`ARTPWM_IDX_OUTCTL, 8'h80, 2'h0);
        repeat (4) @(posedge clk);
        chk(pwm, {pwm_level(c, d, 1'h0), 3'h0});
        $display("test pwm done");
        for (k = 0; k < 2; k = k + 1) begin
            seed = lfsr(seed);
            v = seed[7:0];
            if (k == 1) pins.set_cap(1, 1'h1);
            repeat (8) @(posedge clk);
            ccs = (k == 0) ? 8'h14 : 8'h08;
            wr(`ARTPWM_IDX_CCS, ccs, 2'h0);
            wr(`ARTPWM_IDX_CNT, v, 2'h0);
            pins.set_cap(k, k == 0);
            repeat (10) @(posedge clk);
            chk(cap_irq, 2'h1 << k);
            rdx(`ARTPWM_IDX_CCS, ccs | (8'h01 << k));
            rdx(`ARTPWM_IDX_CAP1 + k[7:0], v);
            rdx(`ARTPWM_IDX_CCS, ccs);
        end
        $display("test capture done");
        wr(`ARTPWM_IDX_RELOAD, 8'h00, 2'h0);
        wr(`ARTPWM_IDX_CNT, 8'h00, 2'h0);
        wr(`ARTPWM_IDX_TCS, 8'h88, 2'h0);
        pins.ext_pulses(5);
        repeat (10) @(posedge clk);
        wr(`ARTPWM_IDX_TCS, 8'h00, 2'h0);
        rdx(`ARTPWM_IDX_CNT, 8'h05);
        // force clears the prescaler so the first tick lands 128 clocks in
        wr(`ARTPWM_IDX_TCS, 8'h7C, 2'h0);
        repeat (200) @(posedge clk);
        wr(`ARTPWM_IDX_TCS, 8'h00, 2'h0);
        rdx(`ARTPWM_IDX_CNT, 8'h01);
        $display("test clocks done");
        conclude;
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares = miscompares + 1;
        $display("watchdog expired");
        conclude;
    end
endmodule // artpwm_timer_tb
